// [hw/wtu_pkg.sv]
// constants shared by the watchdog timeout unit
// assumes the whole block runs on the crystal clock and software reaches it over a plain strobe port
//
// Summary of operation
// - a 6-bit watchdog counter advances on each overflow of a 12-bit prescaler.
// - prescaler and counter run only on the crystal clock, never the bus clock.
// - unserviced, expiry comes after 8176 or 262128 crystal cycles, picked by rate select.
// - any write to the service location clears counter and prescaler stages 12 to 4.
// - reading the service location returns the reset vector low byte, not watchdog state.
// - expiry drives the reset pin low 32 cycles and sets the watchdog cause flag.
// - an effective STOP instruction clears the prescaler.
// - 4096 crystal cycles after power-up the prescaler is cleared once.
// - any internal reset clears both prescaler and counter.
// - the reset vector address seen during a vector fetch clears the prescaler.
// - the disable input from the mask option bit suppresses all timeouts.
// - the rate select input from the mask option bit picks the timeout length.
// - no interrupt request is ever made; expiry only causes a reset.
// - in monitor mode, test voltage on interrupt or reset pin disables the watchdog.
// - in break state, test voltage on the reset pin disables the watchdog.
// - counting continues in wait mode and a timeout still resets.
// - stop mode freezes the watchdog clock path and clears the prescaler.
// - STOP takes effect only when the stop-allow option bit is 1.

package wtu_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// register map
	localparam logic [15:0] MASK_OPTION_ADDR = 16'h001f;
	localparam logic [15:0] SERVICE_ADDR     = 16'hffff;
	localparam logic [15:0] VECTOR_ADDR      = 16'hfffe;
	localparam logic [15:0] RESET_CAUSE_ADDR = 16'hfe01;

	// mask option register bit positions
	localparam int unsigned MOPT_DISABLE_BIT = 0;
	localparam int unsigned MOPT_STOP_BIT    = 1;
	localparam int unsigned MOPT_RATE_BIT    = 7;

	// reset cause register bit position and reset value
	localparam int unsigned CAUSE_WDOG_BIT  = 0;
	localparam logic        CAUSE_RESET_VAL = 1'b0;

	// counter structure
	localparam int unsigned PRESC_W         = 12;
	localparam int unsigned CNT_W           = 6;
	localparam int unsigned SERVICE_CLR_LSB = 3;

	// cycle counts on the crystal clock
	localparam int unsigned TIMEOUT_SHORT_CYCLES = 8176;
	localparam int unsigned TIMEOUT_LONG_CYCLES  = 262128;
	localparam int unsigned POR_DELAY_CYCLES     = 4096;
	localparam int unsigned RST_PULSE_CYCLES     = 32;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOPPED,
		ST_RESET_PULSE
	} wtu_state_type;

endpackage

// [hw/wtu_watchdog.sv]
// watchdog timeout unit: prescaler, timeout counter, reset pulse, cause flag, service register
// assumes clk is the crystal clock, all control inputs are synchronous to it, and the
// register port is a single-cycle strobe master that never waits
//
// The strobed register port was chosen for this implementation.

`timescale 1ns/10ps

module wtu_watchdog
	import wtu_pkg::*;
#(
	parameter int unsigned TIMEOUT_SHORT = TIMEOUT_SHORT_CYCLES,
	parameter int unsigned TIMEOUT_LONG  = TIMEOUT_LONG_CYCLES
) (
	input  wire logic              clk,                 // crystal clock
	input  wire logic              nrst,                // power-on reset, active low
	input  wire logic [ADDR_W-1:0] reg_addr,            // register address
	input  wire logic [DATA_W-1:0] reg_wdata,           // write data (value ignored)
	input  wire logic              reg_wr,              // write strobe
	input  wire logic              reg_rd,              // read strobe
	output logic      [DATA_W-1:0] reg_rdata,           // read data, cycle after strobe
	input  wire logic [DATA_W-1:0] reset_vector_lo,     // low byte of reset vector
	input  wire logic              vector_fetch_in,     // cpu is fetching a vector
	input  wire logic              internal_reset_in,   // any internal reset active
	input  wire logic              stop_instr_in,       // stop instruction executed
	input  wire logic              stop_exit_in,        // wakeup from stop mode
	input  wire logic              wait_mode_in,        // cpu in wait mode
	input  wire logic              watchdog_disable_in, // mask option disable bit
	input  wire logic              rate_select_in,      // mask option rate select bit
	input  wire logic              stop_allow_in,       // mask option stop enable bit
	input  wire logic              monitor_mode_in,     // monitor mode active
	input  wire logic              break_state_in,      // break interrupt active
	input  wire logic              vtst_irq_in,         // test voltage on interrupt pin
	input  wire logic              vtst_rst_in,         // test voltage on reset pin
	output logic                   reset_pin_out,       // reset pin drive level
	output logic                   reset_pin_oe,        // reset pin driven low
	output logic                   watchdog_cause       // watchdog caused last reset
);

	localparam int unsigned TOT_W = PRESC_W + CNT_W;
	localparam int unsigned PULSE_W = $clog2(RST_PULSE_CYCLES);
	localparam int unsigned POR_W = $clog2(POR_DELAY_CYCLES) + 1;
	localparam logic [TOT_W-1:0] LAST_SHORT = TOT_W'(TIMEOUT_SHORT - 1);
	localparam logic [TOT_W-1:0] LAST_LONG = TOT_W'(TIMEOUT_LONG - 1);
	localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(RST_PULSE_CYCLES - 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_DELAY_CYCLES - 1);

	logic                 rst_meta;
	logic                 rst_n;
	wtu_state_type        state;
	logic [PRESC_W-1:0]   presc;
	logic [PRESC_W-1:0]   presc_inc;
	logic [CNT_W-1:0]     wdog_cnt;
	logic [PULSE_W-1:0]   pulse_cnt;
	logic [POR_W-1:0]     por_cnt;
	logic                 por_done;
	logic                 por_clear;
	logic                 disabled;
	logic                 service_wr;
	logic                 vector_hit;
	logic                 stop_take;
	logic                 presc_ovf;
	logic                 expire;
	logic                 cause_rd;
	logic [TOT_W-1:0]     last_count;

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event decode

	// test voltage only matters in monitor or break; plain mask bit always wins
	assign disabled = watchdog_disable_in
		| (monitor_mode_in & (vtst_irq_in | vtst_rst_in))
		| (break_state_in & vtst_rst_in);

	assign service_wr = reg_wr && (reg_addr == SERVICE_ADDR);
	// either byte of the vector pair counts as the vector address on the bus
	assign vector_hit = vector_fetch_in && (reg_addr[ADDR_W-1:1] == VECTOR_ADDR[ADDR_W-1:1]);
	assign stop_take  = stop_instr_in && stop_allow_in && (state == ST_RUN);
	assign cause_rd   = reg_rd && (reg_addr == RESET_CAUSE_ADDR);

	assign presc_inc  = presc + 1'b1;
	assign presc_ovf  = (state == ST_RUN) && (presc == '1);
	// rate select high picks the long period
	assign last_count = rate_select_in ? LAST_LONG : LAST_SHORT;
	// wait mode has no say here, so counting and expiry carry on through it
	assign expire     = (state == ST_RUN) && !disabled
		&& ({wdog_cnt, presc} == last_count);

	////////////////////////////////////////////////////////////////////////////////
	// power-on delay: one prescaler clear after the delay, then idle

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt  <= '0;
			por_done <= 1'b0;
		end else if (!por_done) begin
			por_cnt  <= por_cnt + 1'b1;
			por_done <= (por_cnt == POR_LAST);
		end
	end

	assign por_clear = !por_done && (por_cnt == POR_LAST);

	////////////////////////////////////////////////////////////////////////////////
	// operating state

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_RUN;
			pulse_cnt <= '0;
		end else begin
			case (state)
			ST_RUN: begin
				pulse_cnt <= '0;
				if (expire) begin
					state <= ST_RESET_PULSE;
				end else if (stop_take) begin
					state <= ST_STOPPED;
				end
			end
			ST_STOPPED: begin
				// clock path is gated: nothing advances until wakeup or internal reset
				if (stop_exit_in || internal_reset_in) begin
					state <= ST_RUN;
				end
			end
			ST_RESET_PULSE: begin
				pulse_cnt <= pulse_cnt + 1'b1;
				if (pulse_cnt == PULSE_LAST) begin
					state <= ST_RUN;
				end
			end
			default: begin
				state     <= ST_RUN;
				pulse_cnt <= '0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// prescaler

	// only clk advances it; the bus clock never reaches this logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc <= '0;
		end else if (internal_reset_in || expire || disabled) begin
			presc <= '0;
		end else if (stop_take) begin
			presc <= '0;
		end else if (por_clear || vector_hit) begin
			presc <= '0;
		end else if (service_wr) begin
			// low stages keep running so a service never stretches the period
			presc <= {{(PRESC_W - SERVICE_CLR_LSB){1'b0}}, presc_inc[SERVICE_CLR_LSB-1:0]};
		end else if (state == ST_RUN) begin
			presc <= presc_inc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timeout counter

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_cnt <= '0;
		end else if (internal_reset_in || expire || disabled) begin
			wdog_cnt <= '0;
		end else if (service_wr) begin
			wdog_cnt <= '0;
		end else if (presc_ovf) begin
			wdog_cnt <= wdog_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset pin and cause flag; expiry has no interrupt path, only this reset

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_pin_oe  <= 1'b0;
			reset_pin_out <= 1'b0;
		end else begin
			reset_pin_out <= 1'b0;
			if (expire) begin
				reset_pin_oe <= 1'b1;
			end else if (state == ST_RESET_PULSE && pulse_cnt == PULSE_LAST) begin
				reset_pin_oe <= 1'b0;
			end
		end
	end

	// survives the internal reset it causes; a new expiry beats a clearing read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_cause <= CAUSE_RESET_VAL;
		end else if (expire) begin
			watchdog_cause <= 1'b1;
		end else if (cause_rd) begin
			watchdog_cause <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read port

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= '0;
			case (reg_addr)
			SERVICE_ADDR: begin
				reg_rdata <= reset_vector_lo;
			end
			MASK_OPTION_ADDR: begin
				reg_rdata[MOPT_DISABLE_BIT] <= watchdog_disable_in;
				reg_rdata[MOPT_STOP_BIT]    <= stop_allow_in;
				reg_rdata[MOPT_RATE_BIT]    <= rate_select_in;
			end
			RESET_CAUSE_ADDR: begin
				reg_rdata[CAUSE_WDOG_BIT] <= watchdog_cause;
			end
			default: begin
				reg_rdata <= '0;
			end
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// write data value and wait mode carry no meaning for this block
	logic unused_ok;
	assign unused_ok = ^{reg_wdata, wait_mode_in};

endmodule

// [sim/watchdog_timeout_unit_tb.sv]
// self-checking bench for the watchdog timeout unit
// assumes shortened timeout parameters; the reset pin has a pull-up
`timescale 1ns/10ps
module watchdog_timeout_unit_tb
	import wtu_pkg::*;
;
	localparam int TS = 40;
	localparam int TL = 300;
	logic clk, nrst, reg_wr, reg_rd, vector_fetch_in, internal_reset_in, stop_instr_in, stop_exit_in;
	logic wait_mode_in, watchdog_disable_in, rate_select_in, stop_allow_in, monitor_mode_in, break_state_in;
	logic vtst_irq_in, vtst_rst_in, reset_pin_out, reset_pin_oe, watchdog_cause, rst_pin;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, reset_vector_lo;
	int miscompares = 0;
	int tests_run = 0;
	assign rst_pin = reset_pin_oe ? reset_pin_out : 1'b1;
	wtu_watchdog #(.TIMEOUT_SHORT(TS), .TIMEOUT_LONG(TL)) i_dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .reset_vector_lo, .vector_fetch_in, .internal_reset_in, .stop_instr_in,
		.stop_exit_in, .wait_mode_in, .watchdog_disable_in, .rate_select_in, .stop_allow_in, .monitor_mode_in,
		.break_state_in, .vtst_irq_in, .vtst_rst_in, .reset_pin_out, .reset_pin_oe, .watchdog_cause);
	wtu_cpu_model i_cpu (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .vector_fetch_in);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic results();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// edges until the pin is driven; 999 means it stayed quiet for the whole bound
	task automatic measure(input int bound, output int n);
		n = 999;
		for (int i = 1; i <= bound; i++) begin
			@(posedge clk);
			#1;
			if (reset_pin_oe === 1'b1) begin
				n = i;
				break;
			end
		end
	endtask
	task automatic start();
		internal_reset_in <= 1'b1;
		repeat (2) @(posedge clk);
		internal_reset_in <= 1'b0;
	endtask
	// sel low pulses the stop instruction, sel high the stop wakeup
	task automatic pulse(input bit sel);
		if (sel) begin
			stop_exit_in <= 1'b1;
		end else begin
			stop_instr_in <= 1'b1;
		end
		@(posedge clk);
		stop_exit_in  <= 1'b0;
		stop_instr_in <= 1'b0;
	endtask
	initial begin
		int n, w;
		logic [7:0] d;
		static logic [5:0] row [6] = '{6'h10, 6'h0a, 6'h09, 6'h05, 6'h06, 6'h20};
		static int exp [6] = '{999, 999, 999, 999, TS, TS};
		{nrst, internal_reset_in, stop_instr_in, stop_exit_in, wait_mode_in, rate_select_in} = 6'h00;
		{stop_allow_in, monitor_mode_in, break_state_in, vtst_irq_in, vtst_rst_in} = 5'h00;
		watchdog_disable_in = 1'b1;
		void'($urandom(32'ha36e));
		reset_vector_lo = 8'($urandom);
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		// stay disabled past the one-off power-on prescaler clear
		repeat (4200) @(posedge clk);
		i_cpu.rd(SERVICE_ADDR, d); chk(d, reset_vector_lo);
		i_cpu.rd(MASK_OPTION_ADDR, d); chk(d, 8'h01);
		i_cpu.rd(16'h1234, d); chk(d, 8'h00);
		watchdog_disable_in <= 1'b0;
		for (int r = 0; r < 2; r++) begin
			rate_select_in <= r[0];
			start();
			measure(400, n); chk(n, r ? TL : TS);
			chk(rst_pin, 1'b0);
			chk(watchdog_cause, 1'b1);
			for (w = 0; reset_pin_oe === 1'b1; w++) begin
				if (w > 40) begin
					miscompares++;
					results();
				end
				@(posedge clk);
				#1;
			end
			chk(w, 32);
			i_cpu.rd(RESET_CAUSE_ADDR, d); chk(d, 8'h01);
			i_cpu.rd(RESET_CAUSE_ADDR, d); chk(d, 8'h00);
		end
		rate_select_in <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			{wait_mode_in, watchdog_disable_in, monitor_mode_in, break_state_in, vtst_irq_in, vtst_rst_in} <= row[k];
			start();
			measure(400, n); chk(n, exp[k]);
			{wait_mode_in, watchdog_disable_in, monitor_mode_in, break_state_in, vtst_irq_in, vtst_rst_in} <= 6'h00;
			// once enabled again a full period must not elapse before the next restart
			repeat (36) @(posedge clk);
		end
		start();
		for (int k = 0; k < 5; k++) begin
			measure(30, n); chk(n, 999);
			i_cpu.wr(SERVICE_ADDR, 8'($urandom));
		end
		measure(400, n); chk(n >= TS - 8 && n <= TS, 1'b1);
		repeat (40) @(posedge clk);
		for (int k = 0; k < 2; k++) begin
			start();
			measure(20, n); chk(n, 999);
			i_cpu.fetch(k ? SERVICE_ADDR : VECTOR_ADDR);
			measure(400, n); chk(n, TS);
			repeat (40) @(posedge clk);
		end
		start();
		pulse(1'b0);
		measure(400, n); chk(n, TS - 1);
		repeat (40) @(posedge clk);
		stop_allow_in <= 1'b1;
		start();
		pulse(1'b0);
		measure(200, n); chk(n, 999);
		pulse(1'b1);
		measure(400, n); chk(n >= TS - 2 && n <= TS + 2, 1'b1);
		results();
	end
endmodule

// [sim/wtu_cpu_model.sv]
// cpu software side: register strobes and vector fetches
// assumes strobes are taken at the rising edge and reads answer one cycle later
`timescale 1ns/10ps
module wtu_cpu_model
	import wtu_pkg::*;
(
	input  wire logic              clk,            // crystal clock
	input  wire logic [DATA_W-1:0] reg_rdata,      // read data
	output logic      [ADDR_W-1:0] reg_addr,       // address
	output logic      [DATA_W-1:0] reg_wdata,      // write data
	output logic                   reg_wr,         // write strobe
	output logic                   reg_rd,         // read strobe
	output logic                   vector_fetch_in // vector fetch
);
	initial begin
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		vector_fetch_in = 1'b0;
	end
	// services come from the main flow only, never from a handler
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic fetch(input logic [15:0] a);
		reg_addr <= a;
		vector_fetch_in <= 1'b1;
		@(posedge clk);
		vector_fetch_in <= 1'b0;
	endtask
endmodule

// [sim/wtu_watchdog_assertions.sv]
// port checks for the watchdog timeout unit
// assumes one crystal clock domain with nrst as its reset
`timescale 1ns/10ps
module wtu_watchdog_chk
	import wtu_pkg::*;
#(
	parameter int unsigned TIMEOUT_SHORT = TIMEOUT_SHORT_CYCLES,
	parameter int unsigned TIMEOUT_LONG  = TIMEOUT_LONG_CYCLES
) (
	input wire logic              clk,                 // crystal clock
	input wire logic              nrst,                // reset, active low
	input wire logic [ADDR_W-1:0] reg_addr,            // address
	input wire logic              reg_wr,              // write strobe
	input wire logic              reg_rd,              // read strobe
	input wire logic [DATA_W-1:0] reg_rdata,           // read data
	input wire logic [DATA_W-1:0] reset_vector_lo,     // vector low byte
	input wire logic              internal_reset_in,   // internal reset
	input wire logic              stop_instr_in,       // stop executed
	input wire logic              watchdog_disable_in, // disable bit
	input wire logic              rate_select_in,      // rate bit
	input wire logic              stop_allow_in,       // stop allow bit
	input wire logic              monitor_mode_in,     // monitor mode
	input wire logic              break_state_in,      // break state
	input wire logic              vtst_irq_in,         // test voltage irq pin
	input wire logic              vtst_rst_in,         // test voltage reset pin
	input wire logic              reset_pin_out,       // pin level
	input wire logic              reset_pin_oe,        // pin drive
	input wire logic              watchdog_cause       // cause flag
);
	logic [5:0] hi_cnt;
	logic       dis;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	assign dis = watchdog_disable_in | monitor_mode_in & (vtst_irq_in | vtst_rst_in) | break_state_in & vtst_rst_in;
	// counts sampled edges with the pin driven, so a stretched pulse shows up
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			hi_cnt <= 6'h00;
		else
			hi_cnt <= reset_pin_oe ? hi_cnt + 6'h01 : 6'h00;
	sequence s_svc;
		reg_wr && reg_addr == SERVICE_ADDR;
	endsequence
	sequence s_quiet;
		(!$rose(reset_pin_oe)) [*8];
	endsequence
	pin_low_a: assert property (reset_pin_out == 1'b0) else $error("reset pin level not low");
	pulse_len_a: assert property ($fell(reset_pin_oe) |-> hi_cnt == 6'h20) else $error("pulse length");
	pulse_cap_a: assert property (hi_cnt <= 6'h20) else $error("pulse too long");
	cause_set_a: assert property ($rose(reset_pin_oe) |-> watchdog_cause) else $error("cause not set");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
	svc_read_a: assert property (reg_rd && reg_addr == SERVICE_ADDR |=> reg_rdata == $past(reset_vector_lo))
		else $error("service read data");
	opt_read_a: assert property (reg_rd && reg_addr == MASK_OPTION_ADDR |=> reg_rdata ==
		{$past(rate_select_in), 5'h00, $past(stop_allow_in), $past(watchdog_disable_in)})
		else $error("option read data");
	dis_quiet_a: assert property (dis |=> !$rose(reset_pin_oe)) else $error("timeout while disabled");
	svc_quiet_a: assert property (s_svc |-> ##2 s_quiet) else $error("timeout after service");
	stop_quiet_a: assert property (stop_instr_in && stop_allow_in |-> ##2 s_quiet) else $error("timeout in stop");
	irst_quiet_a: assert property (internal_reset_in ##1 internal_reset_in |=> !$rose(reset_pin_oe))
		else $error("timeout in reset");
endmodule
bind wtu_watchdog wtu_watchdog_chk #(.TIMEOUT_SHORT(TIMEOUT_SHORT), .TIMEOUT_LONG(TIMEOUT_LONG)) i_chk (
	.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reset_vector_lo(reset_vector_lo), .internal_reset_in(internal_reset_in), .stop_instr_in(stop_instr_in),
	.watchdog_disable_in(watchdog_disable_in), .rate_select_in(rate_select_in), .stop_allow_in(stop_allow_in),
	.monitor_mode_in(monitor_mode_in), .break_state_in(break_state_in), .vtst_irq_in(vtst_irq_in),
	.vtst_rst_in(vtst_rst_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
	.watchdog_cause(watchdog_cause));
